//--- bench/tape_delay_gap_timing_test.sv
// self-checking bench for the delay, burst, gap and ending sequence block
`timescale 1ns/1ps
module tape_delay_gap_timing_test;
  import tdg_pkg::*;
  localparam int TB = int'(TB_1600);
  localparam int PP = int'(POST_PERIOD_CYC);
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        parity_write, read_request, hard_error, tape_motion, busy;
  logic        eot_seen, read_ok, noise;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, dsc, dstrap;
  logic [2:0]  hsize;
  tdg_tape_s   tape;
  int          zeros, low_cyc, err_total, cmp_count, n;

  tdg_top u_tdg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tape(tape),
    .density_select_command(dsc), .density_strap(dstrap), .parity_write(parity_write),
    .read_request(read_request), .hard_error(hard_error), .tape_motion(tape_motion),
    .busy(busy));
  tdg_transport u_tdg_transport (.hclk(hclk), .hresetn(hresetn),
    .parity_write(parity_write), .tape_motion(tape_motion), .eot_seen(eot_seen),
    .read_ok(read_ok), .noise(noise), .tape(tape), .zeros(zeros), .low_cyc(low_cyc));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: exp %h got %h", $time, exp, got);
    end
  endtask

  // elapsed cycle counts, bounded on both sides
  task automatic chkr(input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("unexpected at %0t: exp %h..%h got %h", $time, lo, hi, got);
    end
  endtask

  // single word transfer; entered just after a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int t;
    t = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && t < 100) begin
      @(posedge hclk);
      t++;
    end
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && t < 100) begin
      @(posedge hclk);
      t++;
    end
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk32(exp, rd);
  endtask

  task automatic go(input logic [2:0] cmd);
    bus(A_CTRL, 1'b1, {1'b1, 28'h0, cmd});
  endtask

  // busy is only trusted once the go has had time to land
  task automatic wait_done(output int c);
    c = 3;
    repeat (3) @(posedge hclk);
    while (busy !== 1'b0 && c < 200000) begin
      @(posedge hclk);
      c++;
    end
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    dsc <= 2'b00;
    dstrap <= 2'b00;
    go(CMD_DENS);
    wait_done(n);
  endtask

  initial begin
    repeat (100000) @(posedge hclk);
    err_total++;
    end_of_test();
  end

  initial begin
    {hresetn, hsel, hwrite, eot_seen, noise} = '0;
    {haddr, hwdata, htrans, dsc, dstrap} = '0;
    hsize = 3'h2;
    read_ok = 1'b1;
    err_total = 0;
    cmp_count = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk32(32'h1, {31'h0, parity_write});
    rdchk(A_CTRL, 32'h01);
    rdchk(A_GAP, {24'h0, RST_GAP});
    rdchk(8'h20, 32'h0);
    $display("test reset done");
    // every density code, strap folded in by xor
    for (int c = 0; c < 4; c++) begin
      dstrap <= 2'b01;
      dsc <= 2'(c) ^ 2'b01;
      go(CMD_DENS);
      wait_done(n);
      rdchk(A_PRD, {24'h0, (c == 0) ? PRD_PE : PRD_NRZI});
      bus(A_STATUS, 1'b0, 32'h0);
      chk32(32'(c == 0), {31'h0, rd[5]});
    end
    do_reset();
    $display("test density done");
    bus(A_COUNT, 1'b1, 32'h3);
    go(CMD_DELAY);
    repeat (TB) @(posedge hclk);
    eot_seen <= 1'b1;
    repeat (8) @(posedge hclk);
    eot_seen <= 1'b0;
    wait_done(n);
    chkr(3 * TB - 8, 3 * TB + 40, n + TB + 8);
    rdchk(A_SEARCH, {24'h0, EOT_PAT});
    // low byte exhausted with high byte left over
    bus(A_COUNT, 1'b1, 32'h0101);
    go(CMD_DELAY);
    repeat (2 * TB + TB / 2) @(posedge hclk);
    rdchk(A_COUNT, 32'h00ff);
    chk32(32'h1, {31'h0, busy});
    do_reset();
    $display("test delay done");
    bus(A_COUNT, 1'b1, 32'h2);
    go(CMD_ID);
    wait_done(n);
    chkr(4 * TB - 8, 4 * TB + 40, n);
    chk32(32'h2, 32'(zeros));
    chkr(2 * TB - 8, 2 * TB + 16, low_cyc);
    chk32(32'h1, {31'h0, parity_write});
    $display("test burst done");
    bus(A_GAP, 1'b1, 32'h1);
    go(CMD_GAP);
    wait_done(n);
    chkr(6 * TB - 8, 6 * TB + 40, n);
    chk32(32'h0, {31'h0, hard_error});
    // noise mid-window forces one retry; eot seen while waiting
    go(CMD_GAP);
    repeat (3 * TB) @(posedge hclk);
    noise <= 1'b1;
    eot_seen <= 1'b1;
    repeat (4) @(posedge hclk);
    noise <= 1'b0;
    eot_seen <= 1'b0;
    wait_done(n);
    chkr(12 * TB - 8, 12 * TB + 80, n + 3 * TB + 4);
    rdchk(A_GAP, 32'h1);
    rdchk(A_SEARCH, {24'h0, EOT_PAT});
    read_ok <= 1'b0;
    go(CMD_GAP);
    wait_done(n);
    chk32(32'h1, {31'h0, hard_error});
    chk32(32'h0, {31'h0, read_request});
    rdchk(A_CTRL, 32'h01);
    read_ok <= 1'b1;
    do_reset();
    $display("test gap done");
    // plain end and early abort both run the post delay then ramp
    for (int k = 0; k < 2; k++) begin
      bus(A_PRD, 1'b1, 32'h1);
      go((k == 1) ? CMD_ABORT : CMD_END);
      repeat (PP - 200) @(posedge hclk);
      rdchk(A_CTRL, 32'h10);
      repeat (400) @(posedge hclk);
      rdchk(A_CTRL, 32'h20);
      chk32(32'h1, {31'h0, busy});
      do_reset();
    end
    $display("test ending done");
    end_of_test();
  end
endmodule

//--- bench/tdg_transport.sv
// transport model: end-of-tape sensor, read channel and burst monitor
`timescale 1ns/1ps
module tdg_transport
  import tdg_pkg::*;
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          parity_write,
  input  wire logic          tape_motion,
  input  wire logic          eot_seen,
  input  wire logic          read_ok,
  input  wire logic          noise,
  output tdg_pkg::tdg_tape_s tape,
  output int                 zeros,
  output int                 low_cyc
);
  logic pw_q;
  // sensor levels only; search and file mark stay quiet in this model
  always_comb begin
    tape = '0;
    tape.eot = eot_seen;
    tape.read_status = read_ok;
    tape.read_signal = noise;
    tape.forward = tape_motion;
  end
  // inverse polarity channel: a zero half is a low level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pw_q <= 1'b1;
      zeros <= 0;
      low_cyc <= 0;
    end else begin
      pw_q <= parity_write;
      if (pw_q === 1'b1 && parity_write === 1'b0) begin
        zeros <= zeros + 1;
      end
      if (parity_write === 1'b0) begin
        low_cyc <= low_cyc + 1;
      end
    end
  end
endmodule

//--- core/tdg_pkg.sv
// shared constants and types for the tape delay and gap timing block
package tdg_pkg;
  localparam int CLK_MHZ            = 250;
  localparam int POST_PERIOD_US     = 20;
  localparam logic [15:0] POST_PERIOD_CYC = 16'(POST_PERIOD_US * CLK_MHZ);
  // half character periods in clock cycles, selected by density code
  localparam logic [15:0] TB_200  = 16'h3d09;
  localparam logic [15:0] TB_556  = 16'h15f5;
  localparam logic [15:0] TB_800  = 16'h0f42;
  localparam logic [15:0] TB_1600 = 16'h07a1;
  localparam logic [7:0]  PRD_PE   = 8'h0f;
  localparam logic [7:0]  PRD_NRZI = 8'h19;
  localparam logic [7:0]  PRD_RD   = 8'h0a;
  localparam logic [7:0]  EOT_PAT  = 8'haa;
  localparam logic [7:0]  LOW_FILL = 8'hff;
  localparam logic [3:0]  GAP_WIN  = 4'h6;
  localparam logic [15:0] RAMP_CNT = 16'h0100;
  localparam logic [7:0]  RST_GAP  = 8'h04;
  // register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_COUNT  = 8'h04;
  localparam logic [7:0] A_GAP    = 8'h08;
  localparam logic [7:0] A_STATUS = 8'h0c;
  localparam logic [7:0] A_PRD    = 8'h10;
  localparam logic [7:0] A_SEARCH = 8'h14;
  // control command codes (written into ctrl bits 2:0 with bit 31 as go)
  localparam logic [2:0] CMD_DELAY = 3'h1;
  localparam logic [2:0] CMD_ID    = 3'h2;
  localparam logic [2:0] CMD_GAP   = 3'h3;
  localparam logic [2:0] CMD_END   = 3'h4;
  localparam logic [2:0] CMD_ABORT = 3'h5;
  localparam logic [2:0] CMD_DENS  = 3'h6;
  typedef enum logic [7:0] {
    TDG_IDLE  = 8'h01,
    TDG_DELAY = 8'h02,
    TDG_IDW   = 8'h04,
    TDG_GAP   = 8'h08,
    TDG_POST  = 8'h10,
    TDG_RAMP  = 8'h20,
    TDG_DONE  = 8'h40,
    TDG_DEC   = 8'h80
  } tdg_state_e;
  typedef struct packed {
    logic eot;
    logic read_status;
    logic read_signal;
    logic new_cmd;
    logic file_mark;
    logic forward;
    logic search;
    logic file_search;
  } tdg_tape_s;
endpackage

//--- core/tdg_top.sv
// delay, id burst, gap detect and ending sequence timing block
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module tdg_top (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire tdg_pkg::tdg_tape_s tape,
  input  wire logic [1:0]         density_select_command,
  input  wire logic [1:0]         density_strap,
  output logic                    parity_write,
  output logic                    read_request,
  output logic                    hard_error,
  output logic                    tape_motion,
  output logic                    busy
);
  import tdg_pkg::*;

  tdg_state_e  state_r;
  logic [15:0] period_r;
  logic [15:0] period_nxt;
  logic [15:0] timer_r;
  logic        timing_latch_status;
  logic        timer_period_strobe;
  logic        timing_latch_clear_strobe;
  logic [7:0]  count_low_byte;
  logic [7:0]  count_high_byte;
  logic [7:0]  search_indicator;
  logic [7:0]  gap_count_store;
  logic [7:0]  gap_count_working;
  logic [7:0]  post_record_delay_store;
  logic [3:0]  win_r;
  logic        gap_flag;
  logic        half_r;
  logic        format_r;
  logic        stopped_r;
  logic [2:0]  cmd_r;
  logic        go_r;
  logic        wr_pend_r;
  logic [7:0]  wa_r;
  logic [7:0]  ra;
  logic        tick;
  logic        cnt_zero;

  // timing latch poll result; clearing happens same cycle it is seen
  assign tick     = timing_latch_status;
  assign cnt_zero = (count_low_byte | count_high_byte) == 8'h00;

  function automatic logic [15:0] tb_sel(input logic [1:0] cmd, input logic [1:0] strap);
    logic [1:0] code;
    code = cmd ^ strap;
    case (code)
      2'h0:    tb_sel = TB_1600;
      2'h1:    tb_sel = TB_800;
      2'h2:    tb_sel = TB_556;  // fractional divide, slightly slow
      default: tb_sel = TB_200;
    endcase
  endfunction

  // --- ahb-lite slave, zero wait states ---
  assign ra = haddr[7:0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wa_r      <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel && htrans[1] && hwrite;
      wa_r      <= ra;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (ra == A_CTRL) begin
        hrdata <= {24'h000000, state_r};
      end else if (ra == A_COUNT) begin
        hrdata <= {16'h0000, count_high_byte, count_low_byte};
      end else if (ra == A_GAP) begin
        hrdata <= {24'h000000, gap_count_store};
      end else if (ra == A_STATUS) begin
        hrdata <= {24'h000000, busy, stopped_r, format_r, hard_error, gap_flag,
                   read_request, tape_motion, parity_write};
      end else if (ra == A_PRD) begin
        hrdata <= {24'h000000, post_record_delay_store};
      end else if (ra == A_SEARCH) begin
        hrdata <= {24'h000000, search_indicator};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // command capture; the sequencer drops a go pulse unless idle or decelerating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_r  <= 1'b0;
      cmd_r <= 3'h0;
    end else begin
      go_r <= wr_pend_r && (wa_r == A_CTRL) && hwdata[31];
      if (wr_pend_r && (wa_r == A_CTRL)) begin
        cmd_r <= hwdata[2:0];
      end
    end
  end

  // --- timer: programmable period, sets the latch ---
  // new period goes straight into the counter, else first period runs stale
  always_comb begin
    period_nxt = period_r;
    if (timer_period_strobe) begin
      if (state_r == TDG_DONE || state_r == TDG_POST || state_r == TDG_RAMP) begin
        period_nxt = POST_PERIOD_CYC;
      end else begin
        period_nxt = tb_sel(density_select_command, density_strap);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_r <= TB_1600;
    end else begin
      period_r <= period_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_r             <= 16'h0000;
      timing_latch_status <= 1'b0;
    end else begin
      if (timer_period_strobe) begin
        timer_r <= period_nxt;
      end else if (timer_r == 16'h0001 || timer_r == 16'h0000) begin
        timer_r <= period_r;
      end else begin
        timer_r <= timer_r - 16'h0001;
      end
      // set wins over the clear strobe; a period strobe wins over set
      if (timer_r == 16'h0001 && !timer_period_strobe) begin
        timing_latch_status <= 1'b1;
      end else if (timing_latch_clear_strobe || timer_period_strobe) begin
        timing_latch_status <= 1'b0;
      end
    end
  end

  assign timing_latch_clear_strobe = tick;
  assign timer_period_strobe = go_r || (state_r == TDG_DONE);

  // --- main sequencer ---
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= TDG_IDLE;
    end else begin
      case (state_r)
        TDG_IDLE, TDG_DEC: begin
          if (go_r) begin
            case (cmd_r)
              CMD_DELAY: state_r <= TDG_DELAY;
              CMD_ID:    state_r <= TDG_IDW;
              CMD_GAP:   state_r <= TDG_GAP;
              CMD_END:   state_r <= TDG_DONE;
              CMD_ABORT: state_r <= TDG_DONE;
              default:   state_r <= TDG_IDLE;
            endcase
          end else if (state_r == TDG_DEC) begin
            state_r <= TDG_IDLE;
          end
        end
        TDG_DELAY: begin
          if (cnt_zero) begin
            state_r <= TDG_IDLE;
          end
        end
        TDG_IDW: begin
          if (cnt_zero) begin
            state_r <= TDG_IDLE;
          end
        end
        TDG_GAP: begin
          if (!tape.read_status) begin
            state_r <= TDG_DEC;
          end else if (tick && win_r == 4'h1 && gap_flag &&
                       gap_count_working == 8'h01) begin
            if (tape.file_search && search_indicator == EOT_PAT) begin
              state_r <= TDG_DONE;
            end else begin
              state_r <= TDG_IDLE;
            end
          end
        end
        TDG_DONE: state_r <= TDG_POST;
        TDG_POST: begin
          if (cnt_zero) begin
            if (tape.search && !tape.file_mark &&
                !(tape.forward && search_indicator == EOT_PAT)) begin
              state_r <= TDG_GAP;
            end else begin
              state_r <= TDG_RAMP;
            end
          end
        end
        TDG_RAMP: begin
          if (cnt_zero) begin
            state_r <= tape.new_cmd ? TDG_DEC : TDG_IDLE;
          end
        end
        default: state_r <= TDG_IDLE;
      endcase
    end
  end

  // 16-bit countdown shared by delay, id burst, post delay and ramp
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_low_byte  <= 8'h00;
      count_high_byte <= 8'h00;
    end else if (wr_pend_r && wa_r == A_COUNT) begin
      count_low_byte  <= hwdata[7:0];
      count_high_byte <= hwdata[15:8];
    end else if (state_r == TDG_DONE) begin
      count_low_byte  <= post_record_delay_store;
      count_high_byte <= 8'h00;
    end else if (state_r == TDG_POST && cnt_zero) begin
      count_low_byte  <= RAMP_CNT[7:0];
      count_high_byte <= RAMP_CNT[15:8];
    end else if (tick && !cnt_zero && (state_r == TDG_DELAY || state_r == TDG_POST ||
                 state_r == TDG_RAMP || (state_r == TDG_IDW && half_r))) begin
      if (count_low_byte == 8'h00) begin
        count_low_byte  <= LOW_FILL;
        count_high_byte <= count_high_byte - 8'h01;
      end else begin
        count_low_byte <= count_low_byte - 8'h01;
      end
    end
  end

  // id burst: zero half then one half, inverse polarity
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      half_r       <= 1'b0;
      parity_write <= 1'b1;
    end else if (state_r == TDG_IDW && !cnt_zero) begin
      parity_write <= half_r;
      if (tick) begin
        half_r <= !half_r;
      end
    end else begin
      half_r       <= 1'b0;
      parity_write <= 1'b1;
    end
  end

  // gap detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_count_store <= RST_GAP;
    end else if (wr_pend_r && wa_r == A_GAP) begin
      gap_count_store <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_count_working <= 8'h00;
      win_r             <= 4'h0;
      gap_flag          <= 1'b0;
    end else if (state_r != TDG_GAP) begin
      gap_count_working <= gap_count_store;
      win_r             <= GAP_WIN;
      gap_flag          <= 1'b1;
    end else if (tape.read_signal) begin
      gap_flag <= 1'b0;
      if (tick && win_r == 4'h1) begin
        win_r <= GAP_WIN;
      end else if (tick) begin
        win_r <= win_r - 4'h1;
      end
    end else if (tick) begin
      if (win_r != 4'h1) begin
        win_r <= win_r - 4'h1;
      end else begin
        win_r    <= GAP_WIN;
        gap_flag <= 1'b1;
        if (gap_flag) begin
          gap_count_working <= gap_count_working - 8'h01;
        end
      end
    end
  end

  // search indicator, eot watch in every countdown and gap pass
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      search_indicator <= 8'h00;
    end else if (tape.eot && state_r != TDG_IDLE) begin
      search_indicator <= EOT_PAT;
    end else if (state_r == TDG_RAMP && cnt_zero && !tape.new_cmd) begin
      search_indicator <= 8'h00;
    end else if (wr_pend_r && wa_r == A_SEARCH) begin
      search_indicator <= hwdata[7:0];
    end
  end

  // density decode stores post-record delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_record_delay_store <= PRD_PE;
      format_r                <= 1'b0;
    end else if (go_r && cmd_r == CMD_DENS) begin
      format_r <= (density_select_command ^ density_strap) == 2'h0;
      if ((density_select_command ^ density_strap) == 2'h0) begin
        post_record_delay_store <= PRD_PE;
      end else begin
        post_record_delay_store <= PRD_NRZI;
      end
    end else if (wr_pend_r && wa_r == A_PRD) begin
      post_record_delay_store <= hwdata[7:0];
    end
  end

  // control and indicators; format status survives the idle reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      read_request <= 1'b0;
      hard_error   <= 1'b0;
      tape_motion  <= 1'b0;
      stopped_r    <= 1'b1;
      busy         <= 1'b0;
    end else begin
      busy <= state_r != TDG_IDLE;
      if (state_r == TDG_GAP && !tape.read_status) begin
        hard_error   <= 1'b1;
        read_request <= 1'b0;
      end else if (state_r == TDG_GAP) begin
        read_request <= 1'b1;
      end
      if (state_r == TDG_RAMP && cnt_zero) begin
        stopped_r   <= 1'b1;
        tape_motion <= 1'b0;
        if (!tape.new_cmd) begin
          hard_error   <= 1'b0;
          read_request <= 1'b0;
        end
      end else if (state_r == TDG_DELAY || state_r == TDG_GAP || state_r == TDG_IDW) begin
        tape_motion <= 1'b1;
        stopped_r   <= 1'b0;
      end
    end
  end

  a_delay_end: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == TDG_DELAY && cnt_zero |=> state_r == TDG_IDLE)
    else $error("delay did not end at zero count");
  a_low_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == TDG_DELAY && tick && count_low_byte == 8'h00 && count_high_byte != 8'h00
    |=> count_low_byte == 8'hff && count_high_byte == $past(count_high_byte) - 8'h01)
    else $error("low byte reload wrong");
  a_low_dec: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == TDG_DELAY && tick && count_low_byte != 8'h00 && !wr_pend_r
    |=> count_low_byte == $past(count_low_byte) - 8'h01)
    else $error("low byte did not decrement");
  a_latch_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    tick && timer_r != 16'h0001 |=> !timing_latch_status)
    else $error("timing latch not cleared");
  a_eot_load: assert property (@(posedge hclk) disable iff (!hresetn)
    tape.eot && state_r == TDG_DELAY |=> search_indicator == 8'haa)
    else $error("eot not registered");
  a_gap_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == TDG_IDLE ##1 state_r == TDG_IDLE |-> gap_count_working == $past(gap_count_store))
    else $error("gap count not copied");
  a_hard_err: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == TDG_GAP && !tape.read_status |=> hard_error && !read_request
    && state_r == TDG_DEC)
    else $error("read status loss not handled");
  a_end_load: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == TDG_DONE |=> state_r == TDG_POST && count_low_byte ==
    $past(post_record_delay_store) && period_r == POST_PERIOD_CYC)
    else $error("post delay setup wrong");
  a_ramp_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == TDG_RAMP && cnt_zero |=> stopped_r && !tape_motion)
    else $error("tape not stopped after ramp");
  c_delay: cover property (@(posedge hclk) state_r == TDG_DELAY ##1 state_r == TDG_IDLE);
  c_id: cover property (@(posedge hclk) state_r == TDG_IDW && tick && half_r);
  c_gap: cover property (@(posedge hclk) state_r == TDG_GAP ##1 state_r == TDG_IDLE);
  c_ramp: cover property (@(posedge hclk) state_r == TDG_RAMP ##1 state_r == TDG_DEC);
endmodule
